// File: src/sensor_irq_and_fifo_readout.sv
// Sample queue, status flags and interrupt pin logic of the motion sensor.
`timescale 1ns/1ps
module sensor_irq_and_fifo_readout
	import sensor_irq_pkg::*;
#(
	parameter int DEPTH = 512,
	parameter int AW    = 9
) (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        sampleValid,
	output logic             sampleReady,
	input  wire logic [11:0] sampleX,
	input  wire logic [11:0] sampleY,
	input  wire logic [11:0] sampleZ,
	input  wire logic [11:0] sampleTemp,
	input  wire logic        motionEvent,
	input  wire logic        stillnessEvent,
	input  wire logic        readBurst,
	input  wire logic        regRdStb,
	input  wire logic        regWrStb,
	input  wire logic [7:0]  regAddr,
	input  wire logic [7:0]  regWrData,
	output logic [7:0]       regRdData,
	input  wire logic        fifoPop,
	output logic [15:0]      fifoWord,
	input  wire logic        irqPinOneIn,
	output logic             irqPinOneOut,
	output logic             irqPinOneOe,
	input  wire logic        irqPinTwoIn,
	output logic             irqPinTwoOut,
	output logic             irqPinTwoOe,
	output logic             extClockLevel,
	output logic             sampleTrigger
);
	import sensor_irq_pkg::*;

	localparam int CW = AW + 1;                          // Count width
	localparam logic [CW-1:0] FULL = CW'(DEPTH);         // Queue capacity

	// Control registers
	logic [7:0] queueCtrl_q;          // Mode, temperature store, mark high bit
	logic [7:0] queueMark_q;          // Watermark low byte
	logic [7:0] pinOneSourceMap_q;    // Sources routed to pin one
	logic [7:0] pinTwoSourceMap_q;    // Sources routed to pin two
	logic [7:0] filterControlReg_q;   // Trigger select lives here
	logic [7:0] powerControlReg_q;    // Clock select lives here
	logic       externalClockSelect;
	logic       externalTriggerSelect;
	logic [1:0] queueMode;
	logic       tempStore;

	assign externalClockSelect   = powerControlReg_q[BIT_EXTCLK];
	assign externalTriggerSelect = filterControlReg_q[BIT_EXTTRIG];
	assign queueMode             = queueCtrl_q[1:0];
	assign tempStore             = queueCtrl_q[BIT_TEMPSTO];

	// Register writes; other addresses are ignored
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			queueCtrl_q        <= RST_ZERO;
			queueMark_q        <= RST_QMARK;
			pinOneSourceMap_q  <= RST_ZERO;
			pinTwoSourceMap_q  <= RST_ZERO;
			filterControlReg_q <= RST_ZERO;
			powerControlReg_q  <= RST_ZERO;
		end else if (regWrStb) begin
			unique case (regAddr)
				ADDR_QCTRL:  queueCtrl_q        <= regWrData;
				ADDR_QMARK:  queueMark_q        <= regWrData;
				ADDR_MAPONE: pinOneSourceMap_q  <= regWrData;
				ADDR_MAPTWO: pinTwoSourceMap_q  <= regWrData;
				ADDR_FILTER: filterControlReg_q <= regWrData;
				ADDR_POWER:  powerControlReg_q  <= regWrData;
				default: ;
			endcase
		end
	end

	// Input buffer lets the source stall while a set is serialized
	logic        setValid;
	logic        setReady;
	logic [47:0] setData;

	two_entry_buffer #(.WIDTH(48)) u_buf (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.inValid  (sampleValid),
		.inReady  (sampleReady),
		.inData   ({sampleTemp, sampleZ, sampleY, sampleX}),
		.outValid (setValid),
		.outReady (setReady),
		.outData  (setData)
	);

	// Serializer: one queue word per cycle
	ser_state_type serState_q;
	logic [47:0]   setHold_q;        // Set being written
	logic [1:0]    wordIdx_q;        // Also the word type code
	logic          newSet;
	logic          pushValid;
	logic [11:0]   pushRaw;
	logic [15:0]   pushWord;
	logic [1:0]    lastIdx;

	assign setReady  = (serState_q == SER_IDLE);
	assign newSet    = setValid && setReady;
	assign pushValid = (serState_q == SER_EMIT);
	assign lastIdx   = tempStore ? TYPE_TEMP : 2'h2;
	// Only axis and temperature words exist here; no converter path feeds it
	assign pushRaw   = setHold_q[wordIdx_q*12 +: 12];
	assign pushWord  = {wordIdx_q, {2{pushRaw[11]}}, pushRaw};

	// Set sequencing X, Y, Z then optional temperature
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			serState_q <= SER_IDLE;
			setHold_q  <= 48'h0;
			wordIdx_q  <= 2'h0;
		end else begin
			unique case (serState_q)
				SER_IDLE: begin
					if (newSet) begin
						setHold_q  <= setData;
						wordIdx_q  <= 2'h0;
						serState_q <= SER_EMIT;
					end
				end
				SER_EMIT: begin
					if (wordIdx_q == lastIdx) begin
						serState_q <= SER_IDLE;
					end else begin
						wordIdx_q <= wordIdx_q + 2'h1;
					end
				end
			endcase
		end
	end

	// Queue storage and pointers
	logic [15:0]   queueMem [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [CW-1:0] count_q;
	logic          queueOn;
	logic          popEff;
	logic          isFull;
	logic          doWrite;
	logic          dropOld;
	logic          overSet;

	assign queueOn = (queueMode != MODE_OFF);
	assign popEff  = fifoPop && (count_q != '0);
	assign isFull  = (count_q == FULL);
	// Oldest-saved drops the word, other modes discard the oldest
	assign doWrite = pushValid && queueOn && (!isFull || popEff || queueMode != MODE_OLDEST);
	assign dropOld = doWrite && isFull && !popEff;
	assign overSet = pushValid && queueOn && isFull && !popEff;

	// Word write
	always_ff @(posedge ref_clk) begin
		if (doWrite) begin
			queueMem[wrPtr_q] <= pushWord;
		end
	end

	// Pointer and count bookkeeping; disabling empties the queue
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else if (!queueOn) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (doWrite) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (popEff || dropOld) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
			count_q <= count_q + CW'(doWrite && !dropOld) - CW'(popEff);
		end
	end

	// Readout word; an empty queue yields zero
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			fifoWord <= 16'h0000;
		end else if (fifoPop) begin
			fifoWord <= popEff ? queueMem[rdPtr_q] : 16'h0000;
		end
	end

	// Level flags derived from the count
	logic [8:0]    markLevel;        // Watermark in words, kept at full width
	logic          queueReady;
	logic          queueMarkHit;
	logic          overrun_q;

	assign markLevel    = {queueCtrl_q[BIT_MARKHI], queueMark_q};
	assign queueReady   = (count_q != '0);
	// Compared as integers so a shallow queue never truncates the watermark
	assign queueMarkHit = (int'(count_q) >= int'(markLevel));

	// Overrun: a same-cycle readout clear wins and blocks the set; disable clears
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			overrun_q <= 1'b0;
		end else if (!queueOn) begin
			overrun_q <= 1'b0;
		end else begin
			overrun_q <= overSet || (overrun_q && !popEff);
		end
	end

	// Latest sample for the data registers
	logic [47:0] latest_q;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			latest_q <= 48'h0;
		end else if (newSet) begin
			latest_q <= setData;
		end
	end

	// Motion and stillness: event wins over the status-read clear
	logic statusRead;
	logic motionFlag_q;
	logic stillnessFlag_q;

	assign statusRead = regRdStb && (regAddr == ADDR_STATUS);
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			motionFlag_q    <= 1'b0;
			stillnessFlag_q <= 1'b0;
		end else begin
			motionFlag_q    <= motionEvent || (motionFlag_q && !statusRead);
			stillnessFlag_q <= stillnessEvent || (stillnessFlag_q && !statusRead);
		end
	end

	// Data-register read tracking for the new-data flag
	logic isDataAddr;
	logic dataRdStart;
	logic dataRdEnd;
	logic dataRdActive_q;
	logic readyPend_q;
	logic dataReady_q;

	assign isDataAddr  = (regAddr >= ADDR_XHI && regAddr <= ADDR_ZHI) ||
	                     (regAddr >= ADDR_XLO && regAddr <= ADDR_THI);
	assign dataRdStart = regRdStb && isDataAddr && !dataRdActive_q;
	// A read ends when the host closes the burst
	assign dataRdEnd   = dataRdActive_q && !readBurst;

	// Read window opens on the first data address and closes with the burst
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dataRdActive_q <= 1'b0;
		end else if (dataRdStart) begin
			dataRdActive_q <= 1'b1;
		end else if (dataRdEnd) begin
			dataRdActive_q <= 1'b0;
		end
	end

	// Samples arriving mid-read are parked until the read closes
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			readyPend_q <= 1'b0;
		end else if (dataRdStart) begin
			readyPend_q <= newSet;
		end else if (dataRdEnd) begin
			readyPend_q <= 1'b0;
		end else if (dataRdActive_q && newSet) begin
			readyPend_q <= 1'b1;
		end
	end

	// Here the read-start clear deliberately beats a same-cycle sample
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dataReady_q <= 1'b0;
		end else if (dataRdStart) begin
			dataReady_q <= 1'b0;
		end else if (dataRdEnd) begin
			dataReady_q <= readyPend_q || newSet;
		end else if (newSet && !dataRdActive_q) begin
			dataReady_q <= 1'b1;
		end
	end

	// Status assembly; upper bits read zero
	logic [7:0] status;
	assign status = {2'b00, stillnessFlag_q, motionFlag_q, overrun_q,
	                 queueMarkHit, queueReady, dataReady_q};

	// Read mux; unmapped addresses return zero
	function automatic logic [7:0] sign_hi(input logic [11:0] v);
		sign_hi = {{4{v[11]}}, v[11:8]};
	endfunction : sign_hi

	logic [7:0] rdMux;
	always_comb begin
		unique case (regAddr)
			8'h08:       rdMux = latest_q[11:4];
			8'h09:       rdMux = latest_q[23:16];
			8'h0A:       rdMux = latest_q[35:28];
			ADDR_STATUS: rdMux = status;
			8'h0E:       rdMux = latest_q[7:0];
			8'h0F:       rdMux = sign_hi(latest_q[11:0]);
			8'h10:       rdMux = latest_q[19:12];
			8'h11:       rdMux = sign_hi(latest_q[23:12]);
			8'h12:       rdMux = latest_q[31:24];
			8'h13:       rdMux = sign_hi(latest_q[35:24]);
			8'h14:       rdMux = latest_q[43:36];
			8'h15:       rdMux = sign_hi(latest_q[47:36]);
			ADDR_QCTRL:  rdMux = queueCtrl_q;
			ADDR_QMARK:  rdMux = queueMark_q;
			ADDR_MAPONE: rdMux = pinOneSourceMap_q;
			ADDR_MAPTWO: rdMux = pinTwoSourceMap_q;
			ADDR_FILTER: rdMux = filterControlReg_q;
			ADDR_POWER:  rdMux = powerControlReg_q;
			default:     rdMux = 8'h00;
		endcase
	end

	// Read data captured on the strobe, status as seen before its clear
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			regRdData <= 8'h00;
		end else if (regRdStb) begin
			regRdData <= rdMux;
		end
	end

	// Pin drive: OR of mapped sources, polarity, high-Z when unmapped or input
	logic pinOneActive;
	logic pinTwoActive;

	assign pinOneActive = |(status[5:0] & pinOneSourceMap_q[5:0]);
	assign pinTwoActive = |(status[5:0] & pinTwoSourceMap_q[5:0]);
	assign irqPinOneOut = pinOneActive ^ pinOneSourceMap_q[BIT_LOWPOL];
	assign irqPinTwoOut = pinTwoActive ^ pinTwoSourceMap_q[BIT_LOWPOL];
	assign irqPinOneOe  = (|pinOneSourceMap_q[5:0]) && !externalClockSelect;
	assign irqPinTwoOe  = (|pinTwoSourceMap_q[5:0]) && !externalTriggerSelect;

	// Pin inputs pass two flops before any use
	logic [1:0] pinOneSync_q;
	logic [1:0] pinTwoSync_q;
	logic       trigPrev_q;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pinOneSync_q <= 2'b00;
			pinTwoSync_q <= 2'b00;
			trigPrev_q   <= 1'b0;
		end else begin
			pinOneSync_q <= {pinOneSync_q[0], irqPinOneIn};
			pinTwoSync_q <= {pinTwoSync_q[0], irqPinTwoIn};
			trigPrev_q   <= pinTwoSync_q[1];
		end
	end

	// Alternate inputs only reach the core when selected
	assign extClockLevel = externalClockSelect && pinOneSync_q[1];
	assign sampleTrigger = externalTriggerSelect && pinTwoSync_q[1] && !trigPrev_q;

	// Checks
	chk_empty_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
		fifoPop && count_q == '0 |=> fifoWord == 16'h0000) else $error("empty read not zero");
	chk_word_order: assert property (@(posedge ref_clk) disable iff (!nrst)
		pushValid && wordIdx_q != lastIdx |=> pushValid && pushWord[15:14] == $past(wordIdx_q) + 2'h1)
		else $error("set order broken");
	chk_pop_frees: assert property (@(posedge ref_clk) disable iff (!nrst)
		queueOn && popEff && !doWrite |=> count_q == $past(count_q) - 1'b1)
		else $error("read did not free one entry");
	chk_pin_or: assert property (@(posedge ref_clk) disable iff (!nrst)
		irqPinOneOe && (status[5:0] & pinOneSourceMap_q[5:0]) == 6'h0
		|-> irqPinOneOut == pinOneSourceMap_q[BIT_LOWPOL]) else $error("pin one level wrong");
	chk_pin_hiz: assert property (@(posedge ref_clk) disable iff (!nrst)
		pinTwoSourceMap_q[5:0] == 6'h0 |-> !irqPinTwoOe) else $error("unmapped pin driven");
	chk_alt_input: assert property (@(posedge ref_clk) disable iff (!nrst)
		externalClockSelect |-> !irqPinOneOe) else $error("clock pin driven");
	chk_status_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
		statusRead && !motionEvent ##1 !motionEvent |=> !motionFlag_q)
		else $error("motion flag not cleared");
	chk_ready_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
		dataRdActive_q |-> !dataReady_q) else $error("new-data rose during read");
	chk_ready_start: assert property (@(posedge ref_clk) disable iff (!nrst)
		dataRdStart |=> !dataReady_q) else $error("new-data not cleared at read");
	chk_over_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
		popEff && !overSet && queueOn |=> !overrun_q) else $error("overrun not cleared");
	chk_mark_level: assert property (@(posedge ref_clk) disable iff (!nrst)
		$fell(queueMarkHit) && queueOn && $stable(markLevel)
		|-> count_q < markLevel && $past(popEff))
		else $error("watermark fell without readout");
endmodule : sensor_irq_and_fifo_readout

// File: src/sensor_irq_pkg.sv
// Shared constants for the sensor interrupt and queue readout block.
package sensor_irq_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_XHI      = 8'h08;
	localparam logic [7:0] ADDR_ZHI      = 8'h0A;
	localparam logic [7:0] ADDR_STATUS   = 8'h0B;
	localparam logic [7:0] ADDR_XLO      = 8'h0E;
	localparam logic [7:0] ADDR_THI      = 8'h15;
	localparam logic [7:0] ADDR_QCTRL    = 8'h28;
	localparam logic [7:0] ADDR_QMARK    = 8'h29;
	localparam logic [7:0] ADDR_MAPONE   = 8'h2A;
	localparam logic [7:0] ADDR_MAPTWO   = 8'h2B;
	localparam logic [7:0] ADDR_FILTER   = 8'h2C;
	localparam logic [7:0] ADDR_POWER    = 8'h2D;
	// Status and map bit positions
	localparam int BIT_READY    = 0;
	localparam int BIT_QREADY   = 1;
	localparam int BIT_QMARK    = 2;
	localparam int BIT_QOVER    = 3;
	localparam int BIT_MOTION   = 4;
	localparam int BIT_STILL    = 5;
	localparam int BIT_LOWPOL   = 7;
	// Control field positions
	localparam int BIT_EXTCLK   = 6;
	localparam int BIT_EXTTRIG  = 3;
	localparam int BIT_TEMPSTO  = 2;
	localparam int BIT_MARKHI   = 3;
	// Reset values
	localparam logic [7:0] RST_QMARK = 8'h80;
	localparam logic [7:0] RST_ZERO  = 8'h00;
	// Queue modes
	localparam logic [1:0] MODE_OFF    = 2'h0;
	localparam logic [1:0] MODE_OLDEST = 2'h1;
	// Word type codes
	localparam logic [1:0] TYPE_TEMP = 2'h3;
	// Serializer states
	typedef enum logic [1:0] {
		SER_IDLE = 2'b01,
		SER_EMIT = 2'b10
	} ser_state_type;
endpackage : sensor_irq_pkg

// File: src/two_entry_buffer.sv
// Two-entry valid/ready buffer between the sample source and the queue writer.
`timescale 1ns/1ps
module two_entry_buffer #(
	parameter int WIDTH = 48
) (
	input  wire logic             ref_clk,
	input  wire logic             nrst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	logic [WIDTH-1:0] store [2];   // Entry storage
	logic             wrPtr_q;     // Next entry to fill
	logic             rdPtr_q;     // Next entry to drain
	logic [1:0]       fill_q;      // Entries held
	logic             push;
	logic             pop;

	// Full and empty come straight from the fill count
	assign inReady  = (fill_q != 2'h2);
	assign outValid = (fill_q != 2'h0);
	assign outData  = store[rdPtr_q];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// Entry write
	always_ff @(posedge ref_clk) begin
		if (push) begin
			store[wrPtr_q] <= inData;
		end
	end

	// Pointers and count
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wrPtr_q <= 1'b0;
			rdPtr_q <= 1'b0;
			fill_q  <= 2'h0;
		end else begin
			if (push) begin
				wrPtr_q <= ~wrPtr_q;
			end
			if (pop) begin
				rdPtr_q <= ~rdPtr_q;
			end
			fill_q <= fill_q + {1'b0, push} - {1'b0, pop};
		end
	end

	// A stalled word stays put until the reader takes it
	chk_buffer_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
		outValid && !outReady |=> outValid && outData == $past(outData))
		else $error("stalled word lost");
endmodule : two_entry_buffer

// File: verif/host_pin_model.sv
// Host side of the two interrupt pins: bus keepers plus alternate-input drivers.
`timescale 1ns/1ps
module host_pin_model (
	input  wire logic oneOe,
	input  wire logic oneOut,
	input  wire logic twoOe,
	input  wire logic twoOut,
	input  wire logic hostDrvOne,
	input  wire logic hostLvlOne,
	input  wire logic hostDrvTwo,
	input  wire logic hostLvlTwo,
	output logic      pinOne,
	output logic      pinTwo
);
	// Keepers start low; real pins settle somewhere valid
	logic keepOne = 1'b0;
	logic keepTwo = 1'b0;

	// Device wins, then host; keeper holds the last level otherwise
	always @* begin
		if (oneOe) begin
			keepOne = oneOut;
		end else if (hostDrvOne) begin
			keepOne = hostLvlOne;
		end
	end
	// Same resolution for pin two
	always @* begin
		if (twoOe) begin
			keepTwo = twoOut;
		end else if (hostDrvTwo) begin
			keepTwo = hostLvlTwo;
		end
	end
	assign pinOne = keepOne;
	assign pinTwo = keepTwo;
endmodule : host_pin_model

// File: verif/sensor_irq_and_fifo_readout_tb.sv
// Self-checking bench for the sample queue, status flags and pin logic.
`timescale 1ns/1ps
module sensor_irq_and_fifo_readout_tb;
	import sensor_irq_pkg::*;
	logic ref_clk = 1'b0, nrst = 1'b0, sampleValid = 1'b0, sampleReady;
	logic [11:0] sampleX = 12'h000, sampleY = 12'h000, sampleZ = 12'h000, sampleTemp = 12'h000;
	logic motionEvent = 1'b0, stillnessEvent = 1'b0, readBurst = 1'b0;
	logic regRdStb = 1'b0, regWrStb = 1'b0, fifoPop = 1'b0;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
	logic [15:0] fifoWord;
	logic pinOne, pinTwo, oneOut, oneOe, twoOut, twoOe, extClockLevel, sampleTrigger;
	logic drvOne = 1'b0, lvlOne = 1'b0, drvTwo = 1'b0, lvlTwo = 1'b0;
	logic rdD1 = 1'b0, rdD2 = 1'b0, popD1 = 1'b0, popD2 = 1'b0;
	logic [7:0]  rdExp[$];   // Expected register bytes
	logic [15:0] popExp[$];  // Expected queue words
	logic [11:0] sv[3][4];   // Sample sets sent: X, Y, Z, T
	int n_errors = 0, checks = 0, trigCount = 0;

	// Small depth so the full-queue paths are reachable quickly
	sensor_irq_and_fifo_readout #(.DEPTH(8), .AW(3)) uut (
		.ref_clk(ref_clk), .nrst(nrst), .sampleValid(sampleValid), .sampleReady(sampleReady),
		.sampleX(sampleX), .sampleY(sampleY), .sampleZ(sampleZ), .sampleTemp(sampleTemp),
		.motionEvent(motionEvent), .stillnessEvent(stillnessEvent), .readBurst(readBurst),
		.regRdStb(regRdStb), .regWrStb(regWrStb), .regAddr(regAddr), .regWrData(regWrData),
		.regRdData(regRdData), .fifoPop(fifoPop), .fifoWord(fifoWord),
		.irqPinOneIn(pinOne), .irqPinOneOut(oneOut), .irqPinOneOe(oneOe),
		.irqPinTwoIn(pinTwo), .irqPinTwoOut(twoOut), .irqPinTwoOe(twoOe),
		.extClockLevel(extClockLevel), .sampleTrigger(sampleTrigger));
	host_pin_model host (.oneOe(oneOe), .oneOut(oneOut), .twoOe(twoOe), .twoOut(twoOut),
		.hostDrvOne(drvOne), .hostLvlOne(lvlOne), .hostDrvTwo(drvTwo), .hostLvlTwo(lvlTwo),
		.pinOne(pinOne), .pinTwo(pinTwo));

	// 250 MHz clock
	always #2 ref_clk = ~ref_clk;

	// Answers stand one cycle after the strobe edge; delay the strobes to match
	always @(posedge ref_clk) begin
		rdD1 <= regRdStb;
		rdD2 <= rdD1;
		popD1 <= fifoPop;
		popD2 <= popD1;
	end

	// Oldest note is compared whenever an answer lands
	always @(negedge ref_clk) begin
		if (rdD2) cmpVal(regRdData, (rdExp.size() > 0) ? rdExp.pop_front() : 8'hXX);
		if (popD2) cmpVal(fifoWord, (popExp.size() > 0) ? popExp.pop_front() : 16'hXXXX);
		// Trigger pulses counted where they are settled
		if (sampleTrigger === 1'b1) trigCount++;
	end

	task automatic cmpVal(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmpVal

	task automatic cmpBit(input logic got, input logic exp);
		cmpVal({15'h0000, got}, {15'h0000, exp});
	endtask : cmpBit

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk) regWrStb = 1'b1;
		regAddr = a;
		regWrData = d;
		@(negedge ref_clk) regWrStb = 1'b0;
	endtask : wr

	// Gap cycle keeps the answer standing when the monitor looks
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge ref_clk) regRdStb = 1'b1;
		regAddr = a;
		rdExp.push_back(e);
		@(negedge ref_clk) regRdStb = 1'b0;
		@(negedge ref_clk);
	endtask : rd

	task automatic pop(input logic [1:0] t, input logic [11:0] d);
		@(negedge ref_clk) fifoPop = 1'b1;
		popExp.push_back({t, {2{d[11]}}, d});
		@(negedge ref_clk) fifoPop = 1'b0;
		@(negedge ref_clk);
	endtask : pop

	// Offer one random set; held until taken, bounded wait
	task automatic sendSet(input int i);
		int n;
		for (n = 0; n < 4; n++) sv[i][n] = 12'($urandom());
		@(negedge ref_clk) sampleValid = 1'b1;
		{sampleX, sampleY, sampleZ, sampleTemp} = {sv[i][0], sv[i][1], sv[i][2], sv[i][3]};
		n = 0;
		while (sampleReady !== 1'b1 && n < 50) begin
			@(negedge ref_clk) n++;
		end
		if (n >= 50) begin
			n_errors++;
			summarize();
		end
		@(negedge ref_clk) sampleValid = 1'b0;
	endtask : sendSet

	task automatic summarize();
		// Notes never compared count as misses
		n_errors += rdExp.size() + popExp.size();
		$display("errors %0d comparisons %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : summarize

	initial begin
		int k;
		void'($urandom(32'h9380));
		repeat (6) @(negedge ref_clk);
		nrst = 1'b1;
		cmpBit(oneOe, 1'b0);
		cmpBit(twoOe, 1'b0);
		rd(ADDR_STATUS, 8'h00);
		rd(8'h50, 8'h00);
		// Stream mode with temperature, watermark four words
		wr(ADDR_QMARK, 8'h04);
		wr(ADDR_QCTRL, 8'h06);
		wr(ADDR_MAPONE, 8'h03);
		wr(ADDR_MAPTWO, 8'h84);
		cmpBit(oneOut, 1'b0);
		cmpBit(twoOut, 1'b1);
		sendSet(0);
		repeat (12) @(negedge ref_clk);
		rd(ADDR_STATUS, 8'h07);
		cmpBit(oneOut, 1'b1);
		cmpBit(twoOut, 1'b0);
		// New set lands inside an open data read
		readBurst = 1'b1;
		rd(ADDR_XHI, sv[0][0][11:4]);
		sendSet(1);
		repeat (12) @(negedge ref_clk);
		rd(ADDR_STATUS, 8'h06);
		readBurst = 1'b0;
		repeat (2) @(negedge ref_clk);
		rd(ADDR_STATUS, 8'h07);
		for (k = 0; k < 5; k++) pop(2'(k % 4), sv[k / 4][k % 4]);
		rd(ADDR_STATUS, 8'h03);
		for (k = 5; k < 8; k++) pop(2'(k % 4), sv[1][k % 4]);
		pop(2'h0, 12'h000);
		rd(ADDR_STATUS, 8'h01);
		rd(ADDR_XLO, sv[1][0][7:0]);
		rd(ADDR_STATUS, 8'h00);
		cmpBit(oneOut, 1'b0);
		// Motion and stillness raised; only motion mapped to pin two
		wr(ADDR_MAPTWO, 8'h10);
		@(negedge ref_clk) motionEvent = 1'b1;
		stillnessEvent = 1'b1;
		@(negedge ref_clk) motionEvent = 1'b0;
		stillnessEvent = 1'b0;
		repeat (2) @(negedge ref_clk);
		cmpBit(twoOut, 1'b1);
		rd(ADDR_STATUS, 8'h30);
		cmpBit(twoOut, 1'b0);
		// Unmap both pins before reconfiguring the queue
		wr(ADDR_MAPONE, 8'h00);
		wr(ADDR_MAPTWO, 8'h00);
		cmpBit(oneOe, 1'b0);
		wr(ADDR_QCTRL, 8'h00);
		wr(ADDR_QCTRL, 8'h01);
		for (k = 0; k < 3; k++) sendSet(k);
		repeat (30) @(negedge ref_clk);
		rd(ADDR_STATUS, 8'h0F);
		pop(2'h0, sv[0][0]);
		rd(ADDR_STATUS, 8'h07);
		for (k = 1; k < 8; k++) pop(2'(k % 3), sv[k / 3][k % 3]);
		pop(2'h0, 12'h000);
		// Alternate pin uses
		wr(ADDR_MAPONE, 8'h01);
		cmpBit(oneOe, 1'b1);
		cmpBit(extClockLevel, 1'b0);
		wr(ADDR_POWER, 8'h40);
		cmpBit(oneOe, 1'b0);
		drvOne = 1'b1;
		lvlOne = 1'b1;
		repeat (4) @(negedge ref_clk);
		cmpBit(extClockLevel, 1'b1);
		lvlOne = 1'b0;
		repeat (4) @(negedge ref_clk);
		cmpBit(extClockLevel, 1'b0);
		// Trigger selected before mapping, so the pin is never driven high first
		wr(ADDR_FILTER, 8'h08);
		wr(ADDR_MAPTWO, 8'h01);
		cmpBit(twoOe, 1'b0);
		drvTwo = 1'b1;
		lvlTwo = 1'b0;
		repeat (4) @(negedge ref_clk);
		cmpBit(trigCount == 0, 1'b1);
		lvlTwo = 1'b1;
		repeat (6) @(negedge ref_clk);
		lvlTwo = 1'b0;
		repeat (4) @(negedge ref_clk);
		cmpBit(trigCount == 1, 1'b1);
		summarize();
	end
endmodule : sensor_irq_and_fifo_readout_tb
